//--- rtl/gl_pin_function.sv
// General-purpose pin, indicator and serial-memory pin multiplexing
// Summary of operation
// - Speed indicator low: 100M, negotiating, unplugged
// - Speed indicator high only at 10M link
// - Link indicator low while link, no blink
// - Activity drives link indicator high 80 ms
// - Then low at least 80 ms before reblink
// - Duplex indicator low in full duplex only
// - Pins: push-pull, open-drain or input mode
// - Pins zero..two carry speed, link, duplex indicators
// - Data pin: memory, output three, tx enable, tx clock
// - Clock pin: memory, output four, rx valid, rx clock
// - Memory select held inactive while pins reassigned
// - Clock pin sampled once after reset only
// - Crossover enabled when strap high or open
// - General pins raise interrupts, programmable polarity
// - Outputs three and four never interrupt
//
// Added by the designer: the address map and strobed register access.
`timescale 1ns/1ns
`include "gl_defs.svh"
module gl_pin_function #(
  parameter int MS_CYCLES = `GL_MS_CYCLES,
  parameter int BLINK_MS  = `GL_BLINK_MS
) (
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  // Register port
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  output logic             o_irq,
  // Link status from the transceiver
  input  wire logic        i_link_up,
  input  wire logic        i_speed_100,
  input  wire logic        i_autoneg_busy,
  input  wire logic        i_full_duplex,
  input  wire logic        i_tx_activity,
  input  wire logic        i_rx_activity,
  input  wire logic        i_mii_tx_en,
  input  wire logic        i_mii_tx_clk,
  input  wire logic        i_mii_rx_dv,
  input  wire logic        i_mii_rx_clk,
  // Strap and crossover control
  input  wire logic        i_crossover_strap_enable,
  output logic             o_crossover_en,
  output logic             o_factory_test,
  // Serial-memory controller side
  input  wire logic        i_mem_dout,
  input  wire logic        i_mem_dout_oe,
  input  wire logic        i_mem_clk,
  input  wire logic        i_mem_cs,
  output logic             o_mem_din,
  // General pins zero..two
  input  wire logic [2:0]  i_gp_io_i,
  output logic      [2:0]  o_gp_io_o,
  output logic      [2:0]  o_gp_io_oe,
  // Serial-memory pins
  input  wire logic        i_serial_mem_data_pin_i,
  output logic             o_serial_mem_data_pin_o,
  output logic             o_serial_mem_data_pin_oe,
  input  wire logic        i_serial_mem_clock_pin_i,
  output logic             o_serial_mem_clock_pin_o,
  output logic             o_serial_mem_clock_pin_oe,
  output logic             o_serial_mem_select
);
  // ==================================================================
  // State of the whole block
  typedef struct packed {
    logic [`GL_SW-1:0]   s1;       // First synchroniser stage
    logic [`GL_SW-1:0]   s2;       // Second synchroniser stage
    logic [`GL_CFG_W-1:0] cfg;     // Pin configuration
    logic [4:0]          dout;     // Output values, pins and outputs 3/4
    logic [2:0]          ists;     // Sticky interrupt status
    logic [2:0]          imask;    // Interrupt mask
    logic [2:0]          ipol;     // Active level per pin
    logic [2:0]          act_prev; // Active level seen last cycle
    gl_pkg::la_state_e   la_st;    // Link/activity indicator state
    logic                pend;     // Activity seen during blink
    logic [1:0]          strap_cnt;// Cycles since reset release
    logic                strap_done;
    logic                test_bit; // Latched clock pin level
    logic                spd_n;    // Indicator levels
    logic                la_n;
    logic                fdx_n;
    logic [31:0]         rdata;
    logic                irq;
    logic                xover;
    logic                mem_din;
    logic [2:0]          gp_o;
    logic [2:0]          gp_oe;
    logic                dp_o;
    logic                dp_oe;
    logic                cp_o;
    logic                cp_oe;
    logic                sel;
  } state_s;
  state_s q;
  state_s d;
  logic   blink_start;   // Restart the interval timer
  logic   blink_done;    // Interval elapsed
  logic   link;          // Synchronised status
  logic   act;
  logic   wr_cfg;
  logic   wr_data;
  logic   wr_ists;
  logic   wr_imask;
  logic   wr_ipol;
  logic [2:0] gp_in_mode;
  logic [2:0] active;
  logic [2:0] events;
  logic [2:0] led_n;
  gl_pkg::pin_fn_e dfn;
  gl_pkg::pin_fn_e cfn;
  // ==================================================================
  // Interval timer for the activity blink
  gl_blink_timer #(
    .MS_CYCLES (MS_CYCLES),
    .BLINK_MS  (BLINK_MS)
  ) u_timer (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_start   (blink_start),
    .o_done    (blink_done)
  );
  // ==================================================================
  // Next-state logic
  always_comb begin
    d = q;
    // Every pin and status input crosses into this clock first
    d.s1 = {i_serial_mem_clock_pin_i, i_serial_mem_data_pin_i, i_gp_io_i,
            i_crossover_strap_enable, i_mii_rx_clk, i_mii_rx_dv, i_mii_tx_clk,
            i_mii_tx_en, i_rx_activity, i_tx_activity, i_full_duplex,
            i_autoneg_busy, i_speed_100, i_link_up};
    d.s2 = q.s1;
    link = q.s2[`GL_S_LINK];
    act  = q.s2[`GL_S_TXA] | q.s2[`GL_S_RXA];
    dfn  = gl_pkg::pin_fn_e'(q.cfg[`GL_CFG_DFN]);
    cfn  = gl_pkg::pin_fn_e'(q.cfg[`GL_CFG_CFN]);
    // Register writes
    wr_cfg   = i_wr && (i_addr == `GL_REG_CFG);
    wr_data  = i_wr && (i_addr == `GL_REG_DATA);
    wr_ists  = i_wr && (i_addr == `GL_REG_ISTS);
    wr_imask = i_wr && (i_addr == `GL_REG_IMASK);
    wr_ipol  = i_wr && (i_addr == `GL_REG_IPOL);
    if (wr_cfg) begin
      d.cfg = i_wdata[`GL_CFG_W-1:0];
    end
    if (wr_data) begin
      d.dout = i_wdata[4:0];
    end
    if (wr_imask) begin
      d.imask = i_wdata[2:0];
    end
    if (wr_ipol) begin
      d.ipol = i_wdata[2:0];
    end
    // Interrupts only from pins in input mode; outputs 3/4 have no status bit
    gp_in_mode = ~q.cfg[`GL_CFG_DIR] & ~q.cfg[`GL_CFG_LED];
    active     = ~(q.s2[`GL_S_GP] ^ q.ipol) & gp_in_mode;
    events     = active & ~q.act_prev;
    d.act_prev = active;
    // A new event wins over a write-one clear in the same cycle
    d.ists = (q.ists & ~(wr_ists ? i_wdata[2:0] : 3'h0)) | events;
    d.irq  = |(d.ists & d.imask);
    // Strap capture a few cycles after release, once only
    if (!q.strap_done) begin
      if (q.strap_cnt == 2'h2) begin
        d.test_bit   = q.s2[`GL_S_CPIN];
        d.strap_done = 1'b1;
      end else begin
        d.strap_cnt = q.strap_cnt + 2'h1;
      end
    end
    // Strap high or floating (pulled up) enables crossover
    d.xover = q.s2[`GL_S_XOVER];
    // Speed: high only at a settled 10M link
    d.spd_n = link & ~q.s2[`GL_S_SPD100] & ~q.s2[`GL_S_ANEG];
    d.fdx_n = ~q.s2[`GL_S_FDX];
    // Link/activity blink sequence
    blink_start = 1'b0;
    d.pend = q.pend | (act & ((q.la_st == gl_pkg::LA_OFF) || (q.la_st == gl_pkg::LA_HOLD)));
    case (q.la_st)
      gl_pkg::LA_DARK: begin
        d.pend = 1'b0;
        if (link) begin
          d.la_st = gl_pkg::LA_ON;
        end
      end
      gl_pkg::LA_ON: begin
        if (!link) begin
          d.la_st = gl_pkg::LA_DARK;
        end else if (act || q.pend) begin
          d.la_st     = gl_pkg::LA_OFF;
          d.pend      = 1'b0;
          blink_start = 1'b1;
        end
      end
      gl_pkg::LA_OFF: begin
        if (!link) begin
          d.la_st = gl_pkg::LA_DARK;
        end else if (blink_done) begin
          d.la_st     = gl_pkg::LA_HOLD;
          blink_start = 1'b1;
        end
      end
      gl_pkg::LA_HOLD: begin
        // Further activity waits for the full on-interval
        if (!link) begin
          d.la_st = gl_pkg::LA_DARK;
        end else if (blink_done) begin
          d.la_st = gl_pkg::LA_ON;
        end
      end
      default: begin
        d.la_st = gl_pkg::LA_DARK;
      end
    endcase
    d.la_n = (d.la_st != gl_pkg::LA_ON) && (d.la_st != gl_pkg::LA_HOLD);
    // General pins: indicator (open drain) or programmed mode
    led_n = {d.fdx_n, d.la_n, d.spd_n};
    for (int i = 0; i < 3; i++) begin
      if (q.cfg[8 + i]) begin
        d.gp_o[i]  = 1'b0;
        d.gp_oe[i] = ~led_n[i];
      end else if (!q.cfg[i]) begin
        d.gp_o[i]  = 1'b0;
        d.gp_oe[i] = 1'b0;
      end else if (q.cfg[4 + i]) begin
        d.gp_o[i]  = 1'b0;
        d.gp_oe[i] = ~q.dout[i];
      end else begin
        d.gp_o[i]  = q.dout[i];
        d.gp_oe[i] = 1'b1;
      end
    end
    // Serial-memory data pin
    case (dfn)
      gl_pkg::FN_GPO: begin
        d.dp_o  = q.dout[`GL_DAT_GP_OUTPUT_THREE];
        d.dp_oe = 1'b1;
      end
      gl_pkg::FN_SIG: begin
        d.dp_o  = q.s2[`GL_S_TXEN];
        d.dp_oe = 1'b1;
      end
      gl_pkg::FN_CLK: begin
        d.dp_o  = q.s2[`GL_S_TXCLK];
        d.dp_oe = 1'b1;
      end
      default: begin
        d.dp_o  = i_mem_dout;
        d.dp_oe = i_mem_dout_oe;
      end
    endcase
    // Serial-memory clock pin; its input is never used past the strap
    case (cfn)
      gl_pkg::FN_GPO: begin
        d.cp_o = q.dout[`GL_DAT_GP_OUTPUT_FOUR];
      end
      gl_pkg::FN_SIG: begin
        d.cp_o = q.s2[`GL_S_RXDV];
      end
      gl_pkg::FN_CLK: begin
        d.cp_o = q.s2[`GL_S_RXCLK];
      end
      default: begin
        d.cp_o = i_mem_clk;
      end
    endcase
    d.cp_oe = 1'b1;
    // Select stays low unless both pins belong to the memory
    d.sel     = i_mem_cs && (dfn == gl_pkg::FN_MEM) && (cfn == gl_pkg::FN_MEM);
    d.mem_din = q.s2[`GL_S_DPIN];
    // Read data stands only in the cycle after the strobe
    d.rdata = 32'h0;
    if (i_rd) begin
      case (i_addr)
        `GL_REG_CFG:   d.rdata = {16'h0, q.cfg};
        `GL_REG_DATA:  d.rdata = {27'h0, q.dout[4:3], q.s2[`GL_S_GP]};
        `GL_REG_ISTS:  d.rdata = {29'h0, q.ists};
        `GL_REG_IMASK: d.rdata = {29'h0, q.imask};
        `GL_REG_IPOL:  d.rdata = {29'h0, q.ipol};
        `GL_REG_STAT:  d.rdata = {26'h0, q.la_st == gl_pkg::LA_ON, q.fdx_n, q.la_n, q.spd_n,
                                  q.test_bit, q.xover};
        default:       d.rdata = 32'h0;
      endcase
    end
  end
  // ==================================================================
  // Register stage; pins idle and indicators dark during reset
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      q       <= '0;
      q.cfg   <= `GL_CFG_RST;
      q.la_st <= gl_pkg::LA_DARK;
      q.la_n  <= 1'b1;
      q.fdx_n <= 1'b1;
    end else begin
      q <= d;
    end
  end
  // ==================================================================
  // Outputs, all straight from flip-flops
  assign o_rdata                   = q.rdata;
  assign o_irq                     = q.irq;
  assign o_crossover_en            = q.xover;
  assign o_factory_test            = q.test_bit;
  assign o_mem_din                 = q.mem_din;
  assign o_gp_io_o                 = q.gp_o;
  assign o_gp_io_oe                = q.gp_oe;
  assign o_serial_mem_data_pin_o   = q.dp_o;
  assign o_serial_mem_data_pin_oe  = q.dp_oe;
  assign o_serial_mem_clock_pin_o  = q.cp_o;
  assign o_serial_mem_clock_pin_oe = q.cp_oe;
  assign o_serial_mem_select       = q.sel;
  // ==================================================================
  // Checks
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  a_speed_low_100: assert property (q.s2[`GL_S_SPD100] |=> !q.spd_n)
    else $error("speed indicator not low at 100M");
  a_speed_high_10: assert property ((q.s2[`GL_S_LINK] && !q.s2[`GL_S_SPD100] && !q.s2[`GL_S_ANEG])
    |=> q.spd_n)
    else $error("speed indicator not high at 10M");
  a_link_on_low: assert property ((q.la_st == gl_pkg::LA_ON) |-> !q.la_n)
    else $error("link indicator dark while linked");
  a_blink_starts: assert property ((q.la_st == gl_pkg::LA_ON && q.s2[`GL_S_LINK] && act)
    |=> (q.la_st == gl_pkg::LA_OFF) && q.la_n)
    else $error("activity did not start blink");
  a_hold_no_blink: assert property ((q.la_st == gl_pkg::LA_HOLD && !blink_done)
    |=> q.la_st != gl_pkg::LA_OFF)
    else $error("blink restarted during hold");
  a_duplex_low: assert property (q.s2[`GL_S_FDX] |=> !q.fdx_n)
    else $error("duplex indicator not low");
  a_pp_drive: assert property ((q.cfg[0] && !q.cfg[4] && !q.cfg[8])
    |=> o_gp_io_oe[0] == 1'b1)
    else $error("push-pull pin not driven");
  a_select_idle: assert property ((dfn != gl_pkg::FN_MEM || cfn != gl_pkg::FN_MEM)
    |=> !o_serial_mem_select)
    else $error("memory select active while pins reassigned");
  a_strap_stable: assert property (q.strap_done |=> $stable(q.test_bit))
    else $error("strap level changed after capture");
  a_xover_follow: assert property (q.s2[`GL_S_XOVER] |=> o_crossover_en)
    else $error("crossover not enabled by strap");
  a_irq_sticky: assert property ((events[0] && !wr_ists) ##1 !wr_ists |=> q.ists[0])
    else $error("pin event not held in status");
endmodule

//--- rtl/gl_defs.svh
// Offsets, field positions, reset values and timing counts of the pin-function block
`ifndef GL_DEFS_SVH
`define GL_DEFS_SVH
// ====================================================================
// Register offsets (byte addresses)
`define GL_AW          8
`define GL_REG_CFG     8'h00
`define GL_REG_DATA    8'h04
`define GL_REG_ISTS    8'h08
`define GL_REG_IMASK   8'h0c
`define GL_REG_IPOL    8'h10
`define GL_REG_STAT    8'h14
// ====================================================================
// Configuration fields
`define GL_CFG_DIR     2:0
`define GL_CFG_OD      6:4
`define GL_CFG_LED     10:8
`define GL_CFG_DFN     13:12
`define GL_CFG_CFN     15:14
`define GL_CFG_W       16
`define GL_CFG_RST     16'h0700
// Data fields
`define GL_DAT_GP      2:0
`define GL_DAT_GP_OUTPUT_THREE 3
`define GL_DAT_GP_OUTPUT_FOUR  4
// ====================================================================
// Synchroniser vector positions
`define GL_SW          16
`define GL_S_LINK      0
`define GL_S_SPD100    1
`define GL_S_ANEG      2
`define GL_S_FDX       3
`define GL_S_TXA       4
`define GL_S_RXA       5
`define GL_S_TXEN      6
`define GL_S_TXCLK     7
`define GL_S_RXDV      8
`define GL_S_RXCLK     9
`define GL_S_XOVER     10
`define GL_S_GP        13:11
`define GL_S_DPIN      14
`define GL_S_CPIN      15
// ====================================================================
// Timing
`define GL_CLK_MHZ     250
`define GL_BLINK_MS    80
`define GL_MS_CYCLES   (`GL_CLK_MHZ * 1000)
`endif

//--- rtl/gl_pkg.sv
// Types shared by the pin-function block
package gl_pkg;
  // ==================================================================
  // Link/activity indicator states, Gray along on -> off -> hold; hold -> on flips both bits
  typedef enum logic [1:0] {
    LA_ON   = 2'b00,
    LA_OFF  = 2'b01,
    LA_HOLD = 2'b11,
    LA_DARK = 2'b10
  } la_state_e;
  // Function of a serial-memory pin
  typedef enum logic [1:0] {
    FN_MEM  = 2'b00,
    FN_GPO  = 2'b01,
    FN_SIG  = 2'b10,
    FN_CLK  = 2'b11
  } pin_fn_e;
endpackage

//--- rtl/gl_blink_timer.sv
// Millisecond divider and blink interval counter
`timescale 1ns/1ns
`include "gl_defs.svh"
module gl_blink_timer #(
  parameter int MS_CYCLES = `GL_MS_CYCLES,
  parameter int BLINK_MS  = `GL_BLINK_MS
) (
  input  wire logic i_clk,
  input  wire logic i_sys_rst,
  input  wire logic i_start,
  output logic      o_done
);
  localparam int DW = $clog2(MS_CYCLES + 1);
  localparam int MW = $clog2(BLINK_MS + 1);
  // ==================================================================
  // Elaboration check
  if (MS_CYCLES < 1 || BLINK_MS < 1) begin : g_bad
    $error("gl_blink_timer: counts must be at least one");
  end
  typedef struct packed {
    logic [DW-1:0] div;   // Cycle count within one millisecond
    logic [MW-1:0] ms;    // Whole milliseconds elapsed
    logic          run;   // Interval in progress
    logic          done;  // One-cycle end pulse
  } tmr_s;
  tmr_s q;
  tmr_s d;
  logic tick;
  // ==================================================================
  // Next state: restart clears the divider so no partial ms is counted
  always_comb begin
    d    = q;
    tick = (q.div == DW'(MS_CYCLES - 1));
    d.done = 1'b0;
    if (i_start) begin
      d.div = '0;
      d.ms  = '0;
      d.run = 1'b1;
    end else if (q.run) begin
      // One-cycle enable at each millisecond
      d.div = tick ? '0 : DW'(q.div + 1'b1);
      if (tick) begin
        if (q.ms == MW'(BLINK_MS - 1)) begin
          d.run  = 1'b0;
          d.done = 1'b1;
        end else begin
          d.ms = MW'(q.ms + 1'b1);
        end
      end
    end
  end
  // Register stage
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  assign o_done = q.done;
endmodule

//--- test/gl_far_side.sv
// Board model around the pins: pull-ups, LEDs, strap and a floating data line
`timescale 1ns/1ns
module gl_far_side (
  input  wire logic       i_clk,
  input  wire logic [2:0] i_gp_o,
  input  wire logic [2:0] i_gp_oe,
  input  wire logic [2:0] i_ext_en,
  input  wire logic [2:0] i_ext_val,
  input  wire logic       i_dat_o,
  input  wire logic       i_dat_oe,
  input  wire logic       i_ck_o,
  input  wire logic       i_ck_oe,
  input  wire logic       i_strap_low,
  output logic      [2:0] o_gp_pin,
  output logic      [2:0] o_lit,
  output logic            o_dat_pin,
  output logic            o_ck_pin,
  output logic            o_strap
);
  // ==================================================================
  // Pin levels
  logic float_q;  // No memory fitted, so a released data line wanders
  // Plain always: the start value comes from the initial below
  always @(posedge i_clk) begin
    float_q <= ~float_q;
  end
  initial float_q = 1'b0;
  // Design drive wins, then the board driver, else the LED pull-up
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      o_gp_pin[i] = i_gp_oe[i] ? i_gp_o[i] : (i_ext_en[i] ? i_ext_val[i] : 1'b1);
    end
  end
  assign o_lit     = ~o_gp_pin;                     // Cathode low lights the LED
  assign o_dat_pin = i_dat_oe ? i_dat_o : float_q;  // Undriven line is not trusted
  assign o_ck_pin  = i_ck_oe ? i_ck_o : 1'b1;
  assign o_strap   = i_strap_low ? 1'b0 : 1'b1;
endmodule

//--- test/gl_pin_function_tb.sv
// Self-checking bench for the pin-function block
`timescale 1ns/1ns
`include "gl_defs.svh"
module gl_pin_function_tb;
  // ==================================================================
  // Shortened blink timing keeps the run small
  localparam int MS = 4;
  localparam int BL = 3;
  localparam int B  = MS * BL;
  // {link, 100M, negotiating, full duplex, speed lit, duplex lit}
  localparam logic [5:0] TAB [5] = '{6'b000010, 6'b110111, 6'b101010, 6'b100101, 6'b100000};
  logic        clk, rst, wr, rd, link, s100, aneg, fdx, txa, rxa, txen, txck, rxdv, rxck;
  logic        strap_low, mdo, mdoe, mck, mcs, irq, xen, ftest, dpo, dpoe, cpo, cpoe, sel;
  logic        dpin, cpin, strap, mdin;
  logic [7:0]  addr;
  logic [31:0] wdata, o_rdata, rv;
  logic [2:0]  gpo, gpoe, ext_en, ext_val, gp_pin, lit;
  int          err_count, n_checks;
  gl_pin_function #(.MS_CYCLES(MS), .BLINK_MS(BL)) uut (
    .i_clk(clk), .i_sys_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(o_rdata), .o_irq(irq), .i_link_up(link), .i_speed_100(s100), .i_autoneg_busy(aneg),
    .i_full_duplex(fdx), .i_tx_activity(txa), .i_rx_activity(rxa), .i_mii_tx_en(txen),
    .i_mii_tx_clk(txck), .i_mii_rx_dv(rxdv), .i_mii_rx_clk(rxck), .i_crossover_strap_enable(strap),
    .o_crossover_en(xen), .o_factory_test(ftest), .i_mem_dout(mdo), .i_mem_dout_oe(mdoe),
    .i_mem_clk(mck), .i_mem_cs(mcs), .o_mem_din(mdin), .i_gp_io_i(gp_pin), .o_gp_io_o(gpo),
    .o_gp_io_oe(gpoe), .i_serial_mem_data_pin_i(dpin), .o_serial_mem_data_pin_o(dpo),
    .o_serial_mem_data_pin_oe(dpoe), .i_serial_mem_clock_pin_i(cpin), .o_serial_mem_clock_pin_o(cpo),
    .o_serial_mem_clock_pin_oe(cpoe), .o_serial_mem_select(sel));
  gl_far_side board (
    .i_clk(clk), .i_gp_o(gpo), .i_gp_oe(gpoe), .i_ext_en(ext_en), .i_ext_val(ext_val),
    .i_dat_o(dpo), .i_dat_oe(dpoe), .i_ck_o(cpo), .i_ck_oe(cpoe), .i_strap_low(strap_low),
    .o_gp_pin(gp_pin), .o_lit(lit), .o_dat_pin(dpin), .o_ck_pin(cpin), .o_strap(strap));
  // ==================================================================
  // Helpers
  always #2 clk = ~clk;
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wreg(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rreg(logic [7:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    // Sampled mid-cycle, return on an edge so callers drive at edges
    @(negedge clk);
    rv = o_rdata;
    @(posedge clk);
  endtask
  // Bounded wait for an LED to reach a state, counting cycles
  task automatic wait_lit(int i, logic v, int lim, output int n);
    n = 0;
    @(negedge clk);
    while (lit[i] !== v && n < lim) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ==================================================================
  // Scenarios
  task automatic t_reset;
    rreg(`GL_REG_CFG);
    chk("cfg", {16'h0, `GL_CFG_RST}, rv);
    rreg(8'h18);
    chk("unmapped", 32'h0, rv);
    chk("select", 32'h1, {31'h0, sel});
    chk("factory", 32'h1, {31'h0, ftest});
    chk("xover", 32'h1, {31'h0, xen});
  endtask
  // Strap pulled low, clock pin moved low after the capture
  task automatic t_strap;
    strap_low <= 1'b1;
    mck <= 1'b0;
    cyc(5);
    chk("xover low", 32'h0, {31'h0, xen});
    chk("clock pin", 32'h0, {31'h0, cpin});
    rreg(`GL_REG_STAT);
    chk("stat", 32'h2, {30'h0, rv[1:0]});
    strap_low <= 1'b0;
    mck <= 1'b1;
  endtask
  task automatic t_leds;
    for (int i = 0; i < 5; i++) begin
      {link, s100, aneg, fdx} <= TAB[i][5:2];
      cyc(5);
      chk("speed", {31'h0, TAB[i][1]}, {31'h0, lit[0]});
      chk("duplex", {31'h0, TAB[i][0]}, {31'h0, lit[2]});
      chk("link", {31'h0, TAB[i][5]}, {31'h0, lit[1]});
    end
  endtask
  // Activity during the off pulse must come back after the lit gap
  task automatic t_blink;
    int n;
    txa <= 1'b1;
    cyc(2);
    txa <= 1'b0;
    wait_lit(1, 1'b0, 8, n);
    rxa <= 1'b1;
    cyc(2);
    rxa <= 1'b0;
    wait_lit(1, 1'b1, B + 8, n);
    chk("off len", 32'h1, 32'(n + 3 >= B && n + 3 <= B + 4));
    wait_lit(1, 1'b0, B + 8, n);
    chk("gap len", 32'h1, 32'(n >= B && n <= B + 4));
    wait_lit(1, 1'b1, B + 8, n);
    chk("reblink", 32'h1, 32'(n + 1 >= B && n <= B + 4));
  endtask
  task automatic t_gpio;
    wreg(`GL_REG_CFG, 32'h27);
    wreg(`GL_REG_DATA, 32'h5);
    cyc(4);
    chk("pins pp", 32'h5, {29'h0, gp_pin});
    chk("oe pp", 32'h7, {29'h0, gpoe});
    wreg(`GL_REG_DATA, 32'h2);
    cyc(4);
    chk("pins od", 32'h2, {29'h0, gp_pin});
    chk("oe od", 32'h5, {29'h0, gpoe});
    wreg(`GL_REG_CFG, 32'h0);
    ext_en <= 3'b111;
    ext_val <= 3'b110;
    cyc(5);
    rreg(`GL_REG_DATA);
    chk("pins in", 32'h6, {29'h0, rv[2:0]});
  endtask
  task automatic t_irq;
    wreg(`GL_REG_IPOL, 32'h1);
    wreg(`GL_REG_IMASK, 32'h0);
    wreg(`GL_REG_ISTS, 32'h7);
    wreg(`GL_REG_IMASK, 32'h1);
    cyc(2);
    chk("irq idle", 32'h0, {31'h0, irq});
    ext_val <= 3'b111;
    cyc(5);
    chk("irq high", 32'h1, {31'h0, irq});
    rreg(`GL_REG_ISTS);
    chk("ists", 32'h1, rv);
    wreg(`GL_REG_IMASK, 32'h0);
    cyc(2);
    chk("irq masked", 32'h0, {31'h0, irq});
    wreg(`GL_REG_ISTS, 32'h1);
    wreg(`GL_REG_IPOL, 32'h0);
    wreg(`GL_REG_IMASK, 32'h7);
    ext_val <= 3'b011;
    cyc(5);
    rreg(`GL_REG_ISTS);
    chk("ists low", 32'h4, rv);
    chk("irq low", 32'h1, {31'h0, irq});
    wreg(`GL_REG_ISTS, 32'h4);
    cyc(2);
    chk("irq clear", 32'h0, {31'h0, irq});
    ext_en <= 3'b000;
  endtask
  // Every reassigned function of both memory pins, select held off
  task automatic t_mem;
    txen <= 1'b0;
    txck <= 1'b1;
    rxdv <= 1'b1;
    rxck <= 1'b0;
    wreg(`GL_REG_DATA, 32'h8);
    for (int f = 1; f < 4; f++) begin
      wreg(`GL_REG_CFG, 32'(f << 12 | f << 14));
      cyc(5);
      chk("data pin", {30'h0, 1'b1, 1'(3'b101 >> (f - 1))}, {30'h0, dpoe, dpo});
      chk("clock pin", {30'h0, 1'b1, 1'(3'b010 >> (f - 1))}, {30'h0, cpoe, cpo});
      chk("select off", 32'h0, {31'h0, sel});
    end
    wreg(`GL_REG_CFG, 32'h1000);
    cyc(3);
    chk("select one", 32'h0, {31'h0, sel});
    wreg(`GL_REG_DATA, 32'h10);
    rreg(`GL_REG_ISTS);
    chk("gpo no irq", 32'h0, rv);
    wreg(`GL_REG_CFG, 32'h0);
    cyc(3);
    chk("select back", 32'h1, {31'h0, sel});
    chk("clock pass", {31'h0, mck}, {31'h0, cpo});
    // Memory drives the data line, which must come back to it synchronised
    mdo <= 1'b1;
    mdoe <= 1'b1;
    cyc(5);
    chk("data pass", 32'h1, {31'h0, dpin});
    chk("mem din", 32'h1, {31'h0, mdin});
    mcs <= 1'b0;
    cyc(2);
    chk("select cs", 32'h0, {31'h0, sel});
  endtask
  // ==================================================================
  // Main sequence and watchdog
  initial begin
    {clk, wr, rd, link, s100, aneg, fdx, txa, rxa, txen, txck, rxdv, rxck} = '0;
    {strap_low, mdo, mdoe, addr, wdata, ext_en, ext_val} = '0;
    {rst, mck, mcs} = 3'b111;
    err_count = 0;
    n_checks = 0;
    cyc(16);
    rst <= 1'b0;
    cyc(4);
    t_reset;
    t_strap;
    t_leds;
    t_blink;
    t_gpio;
    t_irq;
    t_mem;
    wrap_up;
  end
  initial begin
    #40000;
    err_count++;
    wrap_up;
  end
endmodule
